/* design/flash_cmd_consts.vh */
// Command codes, addresses and timing for the flash command host.
// Included by the host modules; definitions only.
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
`define ADDR_UNLOCK1 12'hAAA
`define ADDR_UNLOCK2 12'h554
`define ADDR_ID 12'h002
`define ADDR_PROT 12'h004
`define DAT_UNLOCK1 8'hAA
`define DAT_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE 8'h80
`define CMD_SECTOR 8'h30
`define CMD_BULK 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hF0
`define CMD_ID 8'h90
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT 8'h00
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_SECTOR_ERASE 4'h2
`define OP_BULK_ERASE 4'h3
`define OP_SUSPEND 4'h4
`define OP_RESUME 4'h5
`define OP_RESET 4'h6
`define OP_READ_ID 4'h7
`define OP_READ_PROT 4'h8
`define OP_BYPASS_ENTER 4'h9
`define OP_BYPASS_EXIT 4'hA
`define OP_ADD_SECTOR 4'hB
`define CLK_NS 8
`define STROBE_CYCLES 4
`define ADD_WINDOW_US 80
// 80 us at the 8 ns clock, sized to the window counter
`define ADD_WINDOW_CYCLES 24'h002710
`endif

/* design/bus_cycle_engine.v */
// One bus cycle on the flash pins: address, write or read strobe low, then high.
// Assumes the device samples address at strobe fall, data at strobe rise.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_consts.vh"
module bus_cycle_engine (
	input wire sysClk,
	input wire rstSyncN,
	input wire clkEn,
	input wire start,
	input wire isWrite,
	input wire [23:0] addrIn,
	input wire [15:0] dataIn,
	input wire [15:0] busDataIn,
	output reg [23:0] busAddr,
	output reg [15:0] busDataOut,
	output reg busDataOeN,
	output reg writeStrobeN,
	output reg readStrobeN,
	output reg [15:0] readData,
	output reg done
);
	reg [3:0] phase_q;
	always @(posedge sysClk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			phase_q <= 4'h0;
			busAddr <= 24'h000000;
			busDataOut <= 16'h0000;
			busDataOeN <= 1'b1;
			writeStrobeN <= 1'b1;
			readStrobeN <= 1'b1;
			readData <= 16'h0000;
			done <= 1'b0;
		end else if (clkEn) begin
			done <= 1'b0;
			if (phase_q == 4'h0) begin
				if (start) begin
					busAddr <= addrIn;
					busDataOut <= dataIn;
					phase_q <= 4'h1;
				end
			end else if (phase_q == 4'h1) begin
				// Address is stable one cycle before the falling strobe
				writeStrobeN <= ~isWrite;
				readStrobeN <= isWrite;
				busDataOeN <= ~isWrite;
				phase_q <= 4'h2;
			end else if (phase_q == `STROBE_CYCLES + 1) begin
				// Data still driven at the rising edge
				if (!readStrobeN)
					readData <= busDataIn;
				writeStrobeN <= 1'b1;
				readStrobeN <= 1'b1;
				phase_q <= phase_q + 4'h1;
			end else if (phase_q == `STROBE_CYCLES + 2) begin
				busDataOeN <= 1'b1;
				done <= 1'b1;
				phase_q <= 4'h0;
			end else begin
				phase_q <= phase_q + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* design/flash_command_host.v */
// Host that issues flash command sequences over a parallel MCU bus.
// Assumes the flash device is outside, with sector selects driven here.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_consts.vh"
module flash_command_host (
	input wire sysClk,
	input wire rst_n,
	input wire clkEn,
	input wire reqValid,
	output wire reqReady,
	input wire [3:0] reqOp,
	input wire reqSecondary,
	input wire [3:0] reqSector,
	input wire [23:0] reqAddr,
	input wire [15:0] reqData,
	input wire codeInSecondary,
	output reg rspValid,
	output reg [15:0] rspData,
	output reg rspRefused,
	output reg bypassActive,
	output reg suspendActive,
	output reg eraseRunning,
	output reg [23:0] busAddr,
	output reg [15:0] busDataOut,
	input wire [15:0] busDataIn,
	output reg busDataOeN,
	output reg writeStrobeN,
	output reg readStrobeN,
	output reg [15:0] primarySectorSelect,
	output reg [3:0] secondarySectorSelect,
	input wire readyBusyPin
);
	localparam S_IDLE = 3'd0;
	localparam S_SEQ = 3'd1;
	localparam S_WAIT = 3'd2;
	localparam S_DONE = 3'd3;
	localparam S_POLL = 3'd4;
	reg rstMeta_q, rstSync_q;
	always @(posedge sysClk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	reg [2:0] state_q;
	reg [2:0] step_q;
	reg [2:0] steps_q;
	reg [3:0] op_q;
	reg sec_q;
	reg [3:0] sector_q;
	reg [23:0] addr_q;
	reg [15:0] data_q;
	reg [23:0] addTimer_q;
	reg start;
	reg isWrite;
	reg [23:0] cyAddr;
	reg [15:0] cyData;
	wire cyDone;
	wire [15:0] cyRead;
	wire [23:0] engAddr;
	wire [15:0] engDataOut;
	wire engOeN, engWrN, engRdN;
	// Low twelve bits carry the code; upper bits follow the target
	function [23:0] cmdAddr;
		input [23:0] base;
		input [11:0] low;
		begin
			cmdAddr = {base[23:12], low};
		end
	endfunction
	// Sequence length in bus cycles per operation
	function [2:0] seqLen;
		input [3:0] op;
		input byp;
		begin
			case (op)
			`OP_PROGRAM: seqLen = byp ? 3'd2 : 3'd4;
			`OP_SECTOR_ERASE: seqLen = 3'd6;
			`OP_BULK_ERASE: seqLen = 3'd6;
			`OP_READ_ID: seqLen = 3'd4;
			`OP_READ_PROT: seqLen = 3'd4;
			`OP_BYPASS_ENTER: seqLen = 3'd3;
			`OP_BYPASS_EXIT: seqLen = 3'd2;
			default: seqLen = 3'd1;
			endcase
		end
	endfunction
	// Code array may only be read or reset, whatever the command
	wire ownOk = (reqSecondary != codeInSecondary) || (reqOp == `OP_READ) ||
		(reqOp == `OP_RESET);
	wire legal = ownOk && ((reqOp == `OP_SUSPEND) ? eraseRunning && !suspendActive :
		(reqOp == `OP_RESUME) ? suspendActive :
		(reqOp == `OP_ADD_SECTOR) ? (addTimer_q != 24'h000000) :
		(reqOp == `OP_BYPASS_EXIT) ? bypassActive :
		((reqOp == `OP_SECTOR_ERASE) || (reqOp == `OP_BULK_ERASE)) ?
		!eraseRunning && !bypassActive : 1'b1);
	assign reqReady = (state_q == S_IDLE) && rstSync_q;
	// Current cycle of the sequence
	always @* begin
		isWrite = 1'b1;
		cyAddr = cmdAddr(addr_q, `ADDR_UNLOCK1);
		cyData = {8'h00, `DAT_UNLOCK1};
		if (bypassActive && op_q == `OP_PROGRAM) begin
			if (step_q == 3'd0)
				cyData = {8'h00, `CMD_PROGRAM};
			else begin
				cyAddr = {addr_q[23:1], 1'b0};
				cyData = data_q;
			end
		end else if (op_q == `OP_BYPASS_EXIT) begin
			cyData = (step_q == 3'd0) ? {8'h00, `CMD_ID} : {8'h00, `CMD_BYPASS_EXIT};
		end else if (steps_q == 3'd1) begin
			case (op_q)
			`OP_READ: begin
				isWrite = 1'b0;
				cyAddr = addr_q;
			end
			`OP_SUSPEND: cyData = {8'h00, `CMD_SUSPEND};
			`OP_RESUME: cyData = {8'h00, `CMD_RESUME};
			`OP_ADD_SECTOR: begin
				cyAddr = {addr_q[23:1], 1'b0};
				cyData = {8'h00, `CMD_SECTOR};
			end
			default: cyData = {8'h00, `CMD_RESET};
			endcase
		end else begin
			case (step_q)
			3'd0, 3'd3: begin
				cyData = {8'h00, `DAT_UNLOCK1};
				if (step_q == 3'd3 && op_q != `OP_SECTOR_ERASE && op_q != `OP_BULK_ERASE) begin
					if (op_q == `OP_PROGRAM) begin
						cyAddr = {addr_q[23:1], 1'b0};
						cyData = data_q;
					end else begin
						isWrite = 1'b0;
						cyAddr = cmdAddr(addr_q, (op_q == `OP_READ_ID) ? `ADDR_ID : `ADDR_PROT);
					end
				end
			end
			3'd1, 3'd4: begin
				cyAddr = cmdAddr(addr_q, `ADDR_UNLOCK2);
				cyData = {8'h00, `DAT_UNLOCK2};
			end
			3'd2: begin
				case (op_q)
				`OP_PROGRAM: cyData = {8'h00, `CMD_PROGRAM};
				`OP_BYPASS_ENTER: cyData = {8'h00, `CMD_BYPASS};
				`OP_READ_ID, `OP_READ_PROT: cyData = {8'h00, `CMD_ID};
				default: cyData = {8'h00, `CMD_ERASE};
				endcase
			end
			default: begin
				if (op_q == `OP_SECTOR_ERASE) begin
					cyAddr = {addr_q[23:1], 1'b0};
					cyData = {8'h00, `CMD_SECTOR};
				end else
					cyData = {8'h00, `CMD_BULK};
			end
			endcase
		end
	end
	wire busyOp = (op_q == `OP_PROGRAM) || (op_q == `OP_SECTOR_ERASE) ||
		(op_q == `OP_BULK_ERASE) || (op_q == `OP_RESUME);
	always @(posedge sysClk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q <= S_IDLE;
			step_q <= 3'd0;
			steps_q <= 3'd1;
			op_q <= `OP_READ;
			sec_q <= 1'b0;
			sector_q <= 4'h0;
			addr_q <= 24'h000000;
			data_q <= 16'h0000;
			addTimer_q <= 24'h000000;
			start <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 16'h0000;
			rspRefused <= 1'b0;
			bypassActive <= 1'b0;
			suspendActive <= 1'b0;
			eraseRunning <= 1'b0;
		end else if (clkEn) begin
			start <= 1'b0;
			rspValid <= 1'b0;
			if (addTimer_q != 24'h000000)
				addTimer_q <= addTimer_q - 24'h000001;
			case (state_q)
			S_IDLE: begin
				if (reqValid) begin
					if (!legal) begin
						rspValid <= 1'b1;
						rspRefused <= 1'b1;
					end else begin
						op_q <= reqOp;
						sec_q <= reqSecondary;
						sector_q <= reqSector;
						addr_q <= reqAddr;
						data_q <= reqData;
						steps_q <= seqLen(reqOp, bypassActive);
						step_q <= 3'd0;
						start <= 1'b1;
						rspRefused <= 1'b0;
						state_q <= S_SEQ;
					end
				end
			end
			S_SEQ: begin
				if (cyDone) begin
					if (step_q == steps_q - 3'd1) begin
						rspData <= cyRead;
						state_q <= S_WAIT;
					end else begin
						step_q <= step_q + 3'd1;
						start <= 1'b1;
					end
				end
			end
			S_WAIT: begin
				// Device needs a cycle or two before it pulls the pin low
				state_q <= busyOp ? S_POLL : S_DONE;
				if (op_q == `OP_BYPASS_ENTER)
					bypassActive <= 1'b1;
				if (op_q == `OP_BYPASS_EXIT || op_q == `OP_RESET)
					bypassActive <= 1'b0;
				if (op_q == `OP_SECTOR_ERASE || op_q == `OP_ADD_SECTOR)
					addTimer_q <= `ADD_WINDOW_CYCLES;
				if (op_q == `OP_SECTOR_ERASE || op_q == `OP_RESUME)
					eraseRunning <= 1'b1;
				if (op_q == `OP_SUSPEND)
					suspendActive <= 1'b1;
				if (op_q == `OP_RESUME)
					suspendActive <= 1'b0;
				if (op_q == `OP_RESET) begin
					suspendActive <= 1'b0;
					eraseRunning <= 1'b0;
				end
			end
			S_POLL: begin
				if (readyBusyPin) begin
					eraseRunning <= 1'b0;
					state_q <= S_DONE;
				end
			end
			default: begin
				rspValid <= 1'b1;
				state_q <= S_IDLE;
			end
			endcase
		end
	end
	// Select stays on for the whole cycle so the device accepts it
	always @(posedge sysClk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			primarySectorSelect <= 16'h0000;
			secondarySectorSelect <= 4'h0;
			busAddr <= 24'h000000;
			busDataOut <= 16'h0000;
			busDataOeN <= 1'b1;
			writeStrobeN <= 1'b1;
			readStrobeN <= 1'b1;
		end else if (clkEn) begin
			busAddr <= engAddr;
			busDataOut <= engDataOut;
			busDataOeN <= engOeN;
			writeStrobeN <= engWrN;
			readStrobeN <= engRdN;
			if (state_q == S_SEQ) begin
				primarySectorSelect <= sec_q ? 16'h0000 : (16'h0001 << sector_q);
				secondarySectorSelect <= sec_q ? (4'h1 << sector_q[1:0]) : 4'h0;
			end else begin
				primarySectorSelect <= 16'h0000;
				secondarySectorSelect <= 4'h0;
			end
		end
	end
	bus_cycle_engine engine (
		.sysClk(sysClk),
		.rstSyncN(rstSync_q),
		.clkEn(clkEn),
		.start(start),
		.isWrite(isWrite),
		.addrIn(cyAddr),
		.dataIn(cyData),
		.busDataIn(busDataIn),
		.busAddr(engAddr),
		.busDataOut(engDataOut),
		.busDataOeN(engOeN),
		.writeStrobeN(engWrN),
		.readStrobeN(engRdN),
		.readData(cyRead),
		.done(cyDone)
	);
endmodule
`default_nettype wire

/* dv/flash_device_model.sv */
// Behavioural flash device: command decoder, small array, ready/busy pin.
// Assumes the host drives byte-address pins and active-high sector selects.
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
	parameter logic [15:0] ID_CODE = 16'h005A, // Arbitrary value
	parameter int BUSY_NS = 2000
) (
	input wire logic [23:0] busAddr,
	input wire logic [15:0] busDataOut,
	input wire logic writeStrobeN,
	input wire logic readStrobeN,
	input wire logic [15:0] primarySectorSelect,
	input wire logic [3:0] secondarySectorSelect,
	output logic [15:0] busDataIn,
	output logic readyBusyPin
);
	logic [15:0] mem [0:15];
	logic [15:0] last;
	logic [11:0] pa;
	logic [7:0] d;
	logic [2:0] step;
	logic idMode, prog, byp;
	initial begin
		step = 0;
		idMode = 0;
		prog = 0;
		byp = 0;
		last = 0;
		readyBusyPin = 1'b1;
		for (int i = 0; i < 16; i++) mem[i] = 16'h1111 * i;
	end
	task automatic busy();
		readyBusyPin = 1'b0;
		readyBusyPin <= #(BUSY_NS) 1'b1;
	endtask
	always @(negedge writeStrobeN) pa = busAddr[11:0];
	always @(posedge writeStrobeN) if ((|primarySectorSelect) || (|secondarySectorSelect)) begin
		d = busDataOut[7:0];
		if (prog) begin
			mem[pa[4:1]] = busDataOut;
			prog = 0;
			busy();
		end else if (d == 8'hF0) begin
			idMode = 0;
			step = 0;
		end else case (step)
		0: if (byp && d == 8'hA0) prog = 1;
			else if (byp && d == 8'h90) step = 6;
			else step = (d == 8'hAA && pa == 12'hAAA) ? 3'd1 : 3'd0;
		1: step = (d == 8'h55 && pa == 12'h554) ? 3'd2 : 3'd0;
		2: begin
			step = (d == 8'h80) ? 3'd3 : 3'd0;
			prog = d == 8'hA0;
			idMode = d == 8'h90;
			byp = byp | (d == 8'h20);
		end
		3: step = (d == 8'hAA) ? 3'd4 : 3'd0;
		4: step = (d == 8'h55) ? 3'd5 : 3'd0;
		5: begin
			step = 0;
			if (d == 8'h30 || d == 8'h10) busy();
		end
		default: begin
			step = 0;
			if (d == 8'h00) byp = 0;
		end
		endcase
	end
	// Released bus shows inverted data so a stale capture cannot match
	always @(negedge readStrobeN) #20 last = busDataIn;
	assign busDataIn = readStrobeN ? ~last : idMode ? (busAddr[2:0] == 3'h2 ? ID_CODE : 16'h0000)
		: mem[busAddr[4:1]];
endmodule
`default_nettype wire

/* dv/flash_host_assertions.sv */
// Port checker for the flash command host.
// Assumes binding to the host top; clkEn held high by the bench.
`timescale 1ns/10ps
`default_nettype none
module flash_host_assertions (
	input wire sysClk,
	input wire rst_n,
	input wire reqValid,
	input wire reqReady,
	input wire [3:0] reqOp,
	input wire reqSecondary,
	input wire codeInSecondary,
	input wire rspValid,
	input wire rspRefused,
	input wire bypassActive,
	input wire suspendActive,
	input wire eraseRunning,
	input wire [23:0] busAddr,
	input wire [15:0] busDataOut,
	input wire busDataOeN,
	input wire writeStrobeN,
	input wire readStrobeN,
	input wire [15:0] primarySectorSelect,
	input wire [3:0] secondarySectorSelect,
	input wire readyBusyPin
);
	default clocking @(posedge sysClk); endclocking
	default disable iff (!rst_n);
	wire taken = reqValid && reqReady;
	a_select_on_write:
	assert property (!writeStrobeN |-> (|primarySectorSelect) || (|secondarySectorSelect))
		else $error("write strobe without sector select");
	a_one_array:
	assert property (!((|primarySectorSelect) && (|secondarySectorSelect)))
		else $error("both arrays selected");
	a_strobe_width:
	assert property ($fell(writeStrobeN) |-> !writeStrobeN [*4] ##1 writeStrobeN)
		else $error("write strobe width wrong");
	a_stable_in_strobe:
	assert property (!writeStrobeN && !$past(writeStrobeN) |-> $stable(busAddr) && $stable(busDataOut))
		else $error("address or data moved under strobe");
	a_drive_on_write:
	assert property (!writeStrobeN |-> !busDataOeN)
		else $error("data not driven during write");
	a_read_released:
	assert property (!readStrobeN |-> busDataOeN && writeStrobeN)
		else $error("host drives bus during read");
	a_refuse_suspend:
	assert property (taken && reqOp == 4'h4 && !(eraseRunning && !suspendActive) |=> rspValid && rspRefused)
		else $error("suspend not refused");
	a_refuse_resume:
	assert property (taken && reqOp == 4'h5 && !suspendActive |=> rspValid && rspRefused)
		else $error("resume not refused");
	a_refuse_own_code:
	assert property (taken && reqOp != 4'h0 && reqOp != 4'h6 && reqSecondary == codeInSecondary
		|=> rspValid && rspRefused) else $error("command to code array not refused");
	cover property (rspValid && rspRefused);
	cover property (rspValid && !rspRefused && bypassActive);
	cover property ($fell(readyBusyPin));
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the flash command host with a device model.
// Assumes 125 MHz clock; requests driven on the falling edge.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_consts.vh"
module testbench;
	logic sysClk = 0, rst_n = 0, reqValid = 0, reqSecondary = 0, codeInSecondary = 1;
	logic [3:0] reqOp = 0;
	logic [23:0] reqAddr = 0;
	logic [15:0] reqData = 0, rspData, busDataIn, busDataOut, pSel;
	logic reqReady, rspValid, rspRefused, bypassActive, suspendActive, eraseRunning;
	logic [23:0] busAddr;
	logic [3:0] sSel;
	logic busDataOeN, writeStrobeN, readStrobeN, readyBusyPin;
	int numErrors = 0, checked = 0, cycles = 0, n;
	flash_command_host dut (.sysClk, .rst_n, .clkEn(1'b1), .reqValid, .reqReady, .reqOp,
		.reqSecondary, .reqSector(4'h0), .reqAddr, .reqData, .codeInSecondary, .rspValid,
		.rspData, .rspRefused, .bypassActive, .suspendActive, .eraseRunning, .busAddr,
		.busDataOut, .busDataIn, .busDataOeN, .writeStrobeN, .readStrobeN,
		.primarySectorSelect(pSel), .secondarySectorSelect(sSel), .readyBusyPin);
	flash_device_model dev (.busAddr, .busDataOut, .writeStrobeN, .readStrobeN,
		.primarySectorSelect(pSel), .secondarySectorSelect(sSel), .busDataIn, .readyBusyPin);
	initial forever #4 sysClk = ~sysClk;
	// Hang guard on the whole run, well above its expected length in cycles
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			finalReport();
		end
	end
	task automatic finalReport();
		$display("checks %0d mismatches %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic req(input logic [3:0] op, input logic sec, input logic [23:0] a,
		input logic [15:0] dat);
		@(negedge sysClk);
		{reqOp, reqSecondary, reqAddr, reqData, reqValid} = {op, sec, a, dat, 1'b1};
		for (n = 0; reqReady !== 1'b1 && n < 5000; n++) @(negedge sysClk);
		@(negedge sysClk);
		reqValid = 0;
		for (n = 0; rspValid !== 1'b1 && n < 5000; n++) @(negedge sysClk);
		if (rspValid !== 1'b1) begin
			numErrors++;
			$display("mismatch rspValid expected 1 seen %b", rspValid);
		end
	endtask
	task automatic tRead();
		req(`OP_READ, 0, 24'h000006, 0);
		chk("primary read", 16'h3333, rspData);
		req(`OP_READ, 1, 24'h000008, 0);
		chk("secondary read", 16'h4444, rspData);
	endtask
	task automatic tProgram();
		req(`OP_PROGRAM, 0, 24'h000010, 16'hBEEF);
		chk("program ok", 0, rspRefused);
		chk("ready after program", 1, readyBusyPin);
		req(`OP_READ, 0, 24'h000010, 0);
		chk("program readback", 16'hBEEF, rspData);
	endtask
	task automatic tIdent();
		req(`OP_READ_ID, 0, 24'h000002, 0);
		chk("identifier", 16'h005A, rspData);
		req(`OP_RESET, 0, 24'h000000, 0);
		req(`OP_READ_PROT, 0, 24'h000004, 0);
		chk("protection", 16'h0000, rspData);
		req(`OP_RESET, 0, 24'h000000, 0);
		req(`OP_READ, 0, 24'h000002, 0);
		chk("read after reset", 16'h1111, rspData);
	endtask
	task automatic tBypass();
		req(`OP_BYPASS_ENTER, 0, 24'h000000, 0);
		chk("bypass on", 1, bypassActive);
		req(`OP_PROGRAM, 0, 24'h000014, 16'hCAFE);
		req(`OP_BYPASS_EXIT, 0, 24'h000000, 0);
		chk("bypass off", 0, bypassActive);
		req(`OP_READ, 0, 24'h000014, 0);
		chk("bypass program", 16'hCAFE, rspData);
	endtask
	task automatic tRefuse();
		req(`OP_ADD_SECTOR, 0, 24'h000000, 0);
		chk("add sector refused", 1, rspRefused);
		req(`OP_SUSPEND, 0, 24'h000000, 0);
		chk("suspend refused", 1, rspRefused);
		req(`OP_RESUME, 0, 24'h000000, 0);
		chk("resume refused", 1, rspRefused);
		codeInSecondary = 0;
		req(`OP_PROGRAM, 0, 24'h000018, 16'h1234);
		chk("own array refused", 1, rspRefused);
		req(`OP_SECTOR_ERASE, 0, 24'h000000, 0);
		chk("own array erase refused", 1, rspRefused);
		codeInSecondary = 1;
		req(`OP_READ, 0, 24'h000018, 0);
		chk("refused left array", 16'hCCCC, rspData);
	endtask
	task automatic tErase();
		req(`OP_SECTOR_ERASE, 0, 24'h000000, 0);
		chk("sector erase", 0, rspRefused);
		chk("ready after erase", 1, readyBusyPin);
		req(`OP_ADD_SECTOR, 0, 24'h000000, 0);
		chk("add sector in window", 0, rspRefused);
		req(`OP_BULK_ERASE, 0, 24'h000000, 0);
		chk("bulk erase", 0, rspRefused);
	endtask
	initial begin
		repeat (2) @(negedge sysClk);
		rst_n = 1;
		tRead();
		tProgram();
		tIdent();
		tBypass();
		tRefuse();
		tErase();
		finalReport();
	end
endmodule
bind flash_command_host flash_host_assertions u_chk (.sysClk, .rst_n, .reqValid, .reqReady,
	.reqOp, .reqSecondary, .codeInSecondary, .rspValid, .rspRefused, .bypassActive,
	.suspendActive, .eraseRunning, .busAddr, .busDataOut, .busDataOeN, .writeStrobeN,
	.readStrobeN, .primarySectorSelect, .secondarySectorSelect, .readyBusyPin);
`default_nettype wire
